/* File: common/iim_defines.svh */
`ifndef IIM_DEFINES_SVH
`define IIM_DEFINES_SVH

// register byte offsets on the wishbone slave
`define IIM_OFF_DIN_LOW     8'h00
`define IIM_OFF_DIN_HIGH    8'h04
`define IIM_OFF_AIN_BASE    8'h08
`define IIM_OFF_GP_IN       8'h18
`define IIM_OFF_GP_CTRL     8'h1c
`define IIM_OFF_GP_OUT      8'h20
`define IIM_OFF_SENS_TYPE   8'h24
`define IIM_OFF_TEMP_BASE   8'h28
`define IIM_OFF_HUMID_BASE  8'h48
`define IIM_PAIR_STRIDE     8'h08
`define IIM_HIGH_STEP       8'h04

// reset values
`define IIM_RST_BYTE        8'h00
`define IIM_RST_WORD        16'h0000

// field layout
`define IIM_AIN_BITS        10
`define IIM_AIN_MAX         10'h3ff
`define IIM_GP_PINS         4
`define IIM_SIGN_BIT        15

// averaging and sensor scaling
`define IIM_AVG_SAMPLES     4'ha
`define IIM_DIV10_MUL       14'h199a
`define IIM_DIV10_SHIFT     16
`define IIM_LOW_RES_SCALE   16'h0100
`define IIM_HIGH_RES_SCALE  16'h000a

`endif

/* File: common/iim_pkg.sv */
package iim_pkg;

    // role of a general-purpose pin, two bits per pin in the control byte
    typedef enum logic [1:0] {
        IIM_ROLE_INPUT,
        IIM_ROLE_OUTPUT,
        IIM_ROLE_SENSOR,
        IIM_ROLE_SPARE
    } iim_role_t;

    // one finished analog conversion
    typedef struct packed {
        logic       valid;
        logic       chan;
        logic [9:0] value;
    } iim_adc_smp_t;

    // one decoded sensor reading, sign and magnitude split by the sensor engine
    typedef struct packed {
        logic       valid;
        logic [1:0] pin;
        logic       temp_neg;
        logic [7:0] temp_whole;
        logic [3:0] temp_tenth;
        logic [7:0] humid_whole;
        logic [3:0] humid_tenth;
    } iim_sensor_rd_t;

endpackage

/* File: tb/iim_field_model.sv */
module iim_field_model (
    input  wire logic                    clk_i,
    input  wire logic [3:0]              gp_pin_o,
    input  wire logic [3:0]              gp_pin_oe_n_o,
    input  wire logic [3:0]              gp_pullup_o,
    output iim_pkg::iim_adc_smp_t        adc_o,
    output iim_pkg::iim_sensor_rd_t      sensor_o,
    output logic      [3:0]              gp_level_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] ext_en;
    logic [3:0] ext_val;
    logic       float_pat;

    initial begin
        adc_o = '0;
        sensor_o = '0;
        ext_en = 4'h0;
        ext_val = 4'h0;
        float_pat = 1'b0;
    end

    // floating pins wander so an undriven read proves nothing
    always @(posedge clk_i) begin
        float_pat <= ~float_pat;
    end

    // ------------------------------------------------------------
    // pin wire resolution
    // ------------------------------------------------------------
    // role picks driver
    always @* begin
        for (int i = 0; i < 4; i++) begin
            if (gp_pin_oe_n_o[i] === 1'b0) gp_level_o[i] = gp_pin_o[i];
            else if (ext_en[i]) gp_level_o[i] = ext_val[i];
            else if (gp_pullup_o[i] === 1'b1) gp_level_o[i] = 1'b1;
            else gp_level_o[i] = float_pat ^ i[0];
        end
    end

    // ------------------------------------------------------------
    // converter and sensor pulses, called right after an edge
    // ------------------------------------------------------------
    task automatic send_adc(input logic chan, input logic [9:0] value);
        adc_o <= {1'b1, chan, value};
        @(posedge clk_i);
        adc_o <= '0;
        @(posedge clk_i);
    endtask

    task automatic send_sensor(input logic [1:0] pin, input logic neg, input logic [7:0] tw,
                               input logic [3:0] tt, input logic [7:0] hw, input logic [3:0] ht);
        sensor_o <= {1'b1, pin, neg, tw, tt, hw, ht};
        @(posedge clk_i);
        sensor_o <= '0;
        @(posedge clk_i);
    endtask
endmodule

/* File: tb/test_iim_input_image.sv */
module test_iim_input_image;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    clk_i;
    logic                    rst_i;
    logic                    wb_cyc_i;
    logic                    wb_stb_i;
    logic                    wb_we_i;
    logic [7:0]              wb_adr_i;
    logic [3:0]              wb_sel_i;
    logic [31:0]             wb_dat_i;
    logic [31:0]             wb_dat_o;
    logic                    wb_ack_o;
    logic [15:0]             din_i;
    iim_pkg::iim_adc_smp_t   adc;
    iim_pkg::iim_sensor_rd_t sensor;
    logic [3:0]              gp_level;
    logic [3:0]              gp_pin_o;
    logic [3:0]              gp_pin_oe_n_o;
    logic [3:0]              gp_pullup_o;
    logic [3:0]              gp_sensor_en_o;
    int                      bad_count;
    int                      samples_checked;
    logic [31:0]             rdat;

    iim_input_image DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din_i(din_i), .adc_i(adc), .sensor_i(sensor),
        .gp_pin_i(gp_level), .gp_pin_o(gp_pin_o), .gp_pin_oe_n_o(gp_pin_oe_n_o),
        .gp_pullup_o(gp_pullup_o), .gp_sensor_en_o(gp_sensor_en_o));

    iim_field_model FLD (.clk_i(clk_i), .gp_pin_o(gp_pin_o), .gp_pin_oe_n_o(gp_pin_oe_n_o),
        .gp_pullup_o(gp_pullup_o), .adc_o(adc), .sensor_o(sensor), .gp_level_o(gp_level));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic test_done;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    // starts right after an edge, ends right after the idle edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] wdat, output logic [31:0] got);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wdat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        got = wb_dat_o;
        if (n >= 20) begin
            $display("CHECK FAILED wb_ack_o expected 1 seen timeout");
            bad_count++;
            test_done();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d, input logic [3:0] sel);
        logic [31:0] dummy;
        wb(1'b1, adr, sel, {24'h000000, d}, dummy);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] got;
        wb(1'b0, adr, 4'hf, 32'h00000000, got);
        chk(name, {24'h000000, exp}, got);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        din_i = 16'h0000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("gp_pin_oe_n_o", 32'hf, {28'h0, gp_pin_oe_n_o});
        for (int a = 0; a <= 8'h64; a += 4) begin
            if (a != 8'h18) rd_chk("reset value", a[7:0], 8'h00);
        end
        // digital bytes, two patterns to see refresh
        din_i <= 16'h8001;
        repeat (4) @(posedge clk_i);
        rd_chk("digital_inputs_low", 8'h00, 8'h01);
        rd_chk("digital_inputs_high", 8'h04, 8'h80);
        din_i <= 16'h0180;
        repeat (4) @(posedge clk_i);
        rd_chk("digital_inputs_low", 8'h00, 8'h80);
        rd_chk("digital_inputs_high", 8'h04, 8'h01);
        wr(8'h00, 8'hff, 4'hf);
        rd_chk("read-only byte", 8'h00, 8'h80);
        rd_chk("unmapped", 8'hfc, 8'h00);
        // analog: nine samples leave the word alone, the tenth averages
        for (int i = 0; i < 9; i++) FLD.send_adc(1'b0, 10'h3ff);
        for (int i = 0; i < 10; i++) FLD.send_adc(1'b1, 10'(i * 3));
        rd_chk("analog_result_low ch0", 8'h08, 8'h00);
        FLD.send_adc(1'b0, 10'h3e8);
        rd_chk("analog_result_low ch0", 8'h08, 8'hfc);
        rd_chk("analog_result_high ch0", 8'h0c, 8'h03);
        rd_chk("analog_result_low ch1", 8'h10, 8'h0d);
        rd_chk("analog_result_high ch1", 8'h14, 8'h00);
        for (int i = 0; i < 10; i++) FLD.send_adc(1'b0, 10'h3ff);
        rd_chk("analog_result_low max", 8'h08, 8'hff);
        rd_chk("analog_result_high max", 8'h0c, 8'h03);
        // general pins as inputs, driven then pulled up
        FLD.ext_en <= 4'hf;
        FLD.ext_val <= 4'ha;
        repeat (4) @(posedge clk_i);
        rd_chk("general_pin_inputs", 8'h18, 8'h0a);
        FLD.ext_val <= 4'h5;
        repeat (4) @(posedge clk_i);
        rd_chk("general_pin_inputs", 8'h18, 8'h05);
        FLD.ext_en <= 4'h0;
        wr(8'h20, 8'h0f, 4'h1);
        wr(8'h20, 8'h00, 4'he);
        repeat (4) @(posedge clk_i);
        rd_chk("general_pin_inputs pulled", 8'h18, 8'h0f);
        // pin 0 output, pin 1 sensor, pins 2 and 3 inputs
        wr(8'h1c, {4'h0, iim_pkg::IIM_ROLE_SENSOR, iim_pkg::IIM_ROLE_OUTPUT}, 4'h1);
        chk("gp_pin_oe_n_o", 32'he, {28'h0, gp_pin_oe_n_o});
        chk("gp_pin_o", 32'h1, {28'h0, gp_pin_o & 4'h1});
        chk("gp_pullup_o", 32'hc, {28'h0, gp_pullup_o});
        chk("gp_sensor_en_o", 32'h2, {28'h0, gp_sensor_en_o});
        // low-resolution reading on pin 1, one on a non-sensor pin
        FLD.send_sensor(2'h1, 1'b0, 8'h16, 4'h0, 8'h29, 4'h0);
        FLD.send_sensor(2'h2, 1'b0, 8'h1e, 4'h0, 8'h32, 4'h0);
        rd_chk("temperature_low pin1", 8'h30, 8'h00);
        rd_chk("temperature_high pin1", 8'h34, 8'h16);
        rd_chk("humidity_high pin1", 8'h54, 8'h29);
        rd_chk("temperature_high pin2", 8'h3c, 8'h00);
        // high-resolution, negative
        wr(8'h24, 8'h02, 4'h1);
        FLD.send_sensor(2'h1, 1'b1, 8'h16, 4'h4, 8'h29, 4'h7);
        rd_chk("temperature_low pin1", 8'h30, 8'he0);
        rd_chk("temperature_high pin1", 8'h34, 8'h80);
        rd_chk("humidity_low pin1", 8'h50, 8'ha1);
        rd_chk("humidity_high pin1", 8'h54, 8'h01);
        // a second reset restores pin roles
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("gp_pin_oe_n_o", 32'hf, {28'h0, gp_pin_oe_n_o});
        rd_chk("general_pin_control", 8'h1c, 8'h00);
        test_done();
    end
endmodule

/* File: verilog/iim_input_image.sv */
// Behaviour
// - inputs 0..7 into low byte, LSB first
// - inputs 8..15 into high byte, LSB first
// - bit reads 1 while input active
// - analog result 10 bits in 16-bit word
// - top two bits in high byte bits 1:0
// - store average of ten conversions per channel
// - stored analog value within 0..1023
// - one analog word pair per channel
// - pins 0..3 in bits 0..3, rest zero
// - pin bit reads driven pin level
// - all pins inputs after reset
// - pull-up enabled input idles at 1
// - pin role set by control byte
// - temperature word per pin in sensor mode
// - high-res negative sets temperature MSB
// - humidity word per pin, same scales
`include "iim_defines.svh"

module iim_input_image #(
    parameter int AIN_CHANNELS = 2,
    parameter int GP_PINS      = `IIM_GP_PINS
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic [15:0]            din_i,
    input  wire iim_pkg::iim_adc_smp_t  adc_i,
    input  wire iim_pkg::iim_sensor_rd_t sensor_i,
    input  wire logic [GP_PINS-1:0]     gp_pin_i,
    output logic      [GP_PINS-1:0]     gp_pin_o,
    output logic      [GP_PINS-1:0]     gp_pin_oe_n_o,
    output logic      [GP_PINS-1:0]     gp_pullup_o,
    output logic      [GP_PINS-1:0]     gp_sensor_en_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // reciprocal multiply, exact for sums up to ten full-scale samples
    function automatic logic [9:0] div10(input logic [13:0] sum);
        logic [27:0] prod;
        logic [11:0] q;
        prod = sum * `IIM_DIV10_MUL;
        q    = prod[27:`IIM_DIV10_SHIFT];
        div10 = (q > 12'(`IIM_AIN_MAX)) ? `IIM_AIN_MAX : q[9:0];
    endfunction

    function automatic logic [15:0] scale_word(input logic       hi_res,
                                               input logic       neg,
                                               input logic [7:0] whole,
                                               input logic [3:0] tenth);
        logic [15:0] mag;
        scale_word = `IIM_RST_WORD;
        if (hi_res) begin
            mag        = 16'(whole * `IIM_HIGH_RES_SCALE) + 16'(tenth);
            scale_word = {neg, mag[14:0]};
        end else begin
            mag        = 16'(whole * `IIM_LOW_RES_SCALE);
            scale_word = neg ? 16'(-mag) : mag;
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [15:0]        din_meta;
    logic [15:0]        din_sync;
    logic [GP_PINS-1:0] gp_meta;
    logic [GP_PINS-1:0] gp_sync;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            din_meta <= 16'h0000;
            din_sync <= 16'h0000;
            gp_meta  <= '0;
            gp_sync  <= '0;
        end else begin
            din_meta <= din_i;
            din_sync <= din_meta;
            gp_meta  <= gp_pin_i;
            gp_sync  <= gp_meta;
        end
    end

    // ----------------------------------------------------------------
    // host-written configuration
    // ----------------------------------------------------------------
    logic [7:0]         gp_ctrl;
    logic [GP_PINS-1:0] gp_out;
    logic [GP_PINS-1:0] sens_hi_res;
    logic               wr_en;
    logic               rd_en;

    // write lands at the ack edge, when the master still holds the request
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gp_ctrl     <= `IIM_RST_BYTE;
            gp_out      <= '0;
            sens_hi_res <= '0;
        end else if (wr_en) begin
            if (wb_adr_i == `IIM_OFF_GP_CTRL) begin
                gp_ctrl <= wb_dat_i[7:0];
            end else if (wb_adr_i == `IIM_OFF_GP_OUT) begin
                gp_out <= wb_dat_i[GP_PINS-1:0];
            end else if (wb_adr_i == `IIM_OFF_SENS_TYPE) begin
                sens_hi_res <= wb_dat_i[GP_PINS-1:0];
            end
        end
    end

    iim_pkg::iim_role_t role [GP_PINS];

    always_comb begin
        for (int p = 0; p < GP_PINS; p++) begin
            role[p]          = iim_pkg::iim_role_t'(gp_ctrl[2*p +: 2]);
            gp_pin_oe_n_o[p] = (role[p] != iim_pkg::IIM_ROLE_OUTPUT);
            gp_pin_o[p]      = (role[p] == iim_pkg::IIM_ROLE_OUTPUT) && gp_out[p];
            gp_sensor_en_o[p] = (role[p] == iim_pkg::IIM_ROLE_SENSOR);
            gp_pullup_o[p]   = (role[p] == iim_pkg::IIM_ROLE_INPUT) && gp_out[p];
        end
    end

    // ----------------------------------------------------------------
    // digital and general-purpose input image
    // ----------------------------------------------------------------
    logic [7:0] din_low;
    logic [7:0] din_high;
    logic [7:0] gp_in;

    // refreshed every clock so any host read sees the newest sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            din_low  <= `IIM_RST_BYTE;
            din_high <= `IIM_RST_BYTE;
            gp_in    <= `IIM_RST_BYTE;
        end else begin
            // low byte packing, active reads 1
            din_low  <= din_sync[7:0];
            din_high <= din_sync[15:8];
            gp_in    <= {4'h0, gp_sync[3:0]};
        end
    end

    // ----------------------------------------------------------------
    // analog averaging
    // ----------------------------------------------------------------
    logic [13:0] ain_sum [AIN_CHANNELS];
    logic [3:0]  ain_cnt [AIN_CHANNELS];
    logic [9:0]  ain_val [AIN_CHANNELS];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < AIN_CHANNELS; c++) begin
                ain_sum[c] <= 14'h0000;
                ain_cnt[c] <= 4'h0;
                ain_val[c] <= 10'h000;
            end
        end else if (adc_i.valid) begin
            for (int c = 0; c < AIN_CHANNELS; c++) begin
                if (adc_i.chan == 1'(c)) begin
                    if (ain_cnt[c] == `IIM_AVG_SAMPLES - 4'h1) begin
                        ain_val[c] <= div10(ain_sum[c] + 14'(adc_i.value));
                        ain_sum[c] <= 14'h0000;
                        ain_cnt[c] <= 4'h0;
                    end else begin
                        ain_sum[c] <= ain_sum[c] + 14'(adc_i.value);
                        ain_cnt[c] <= ain_cnt[c] + 4'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // sensor words
    // ----------------------------------------------------------------
    logic [15:0] temp_word  [GP_PINS];
    logic [15:0] humid_word [GP_PINS];

    // readings for a pin not in sensor role are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < GP_PINS; p++) begin
                temp_word[p]  <= `IIM_RST_WORD;
                humid_word[p] <= `IIM_RST_WORD;
            end
        end else if (sensor_i.valid && role[sensor_i.pin] == iim_pkg::IIM_ROLE_SENSOR) begin
            temp_word[sensor_i.pin]  <= scale_word(sens_hi_res[sensor_i.pin], sensor_i.temp_neg,
                                                   sensor_i.temp_whole, sensor_i.temp_tenth);
            humid_word[sensor_i.pin] <= scale_word(sens_hi_res[sensor_i.pin], 1'b0,
                                                   sensor_i.humid_whole, sensor_i.humid_tenth);
        end
    end

    // ----------------------------------------------------------------
    // wishbone read side
    // ----------------------------------------------------------------
    logic [7:0] next_rd;

    always_comb begin
        next_rd = 8'h00;
        if (wb_adr_i == `IIM_OFF_DIN_LOW) begin
            next_rd = din_low;
        end else if (wb_adr_i == `IIM_OFF_DIN_HIGH) begin
            next_rd = din_high;
        end else if (wb_adr_i == `IIM_OFF_GP_IN) begin
            next_rd = gp_in;
        end else if (wb_adr_i == `IIM_OFF_GP_CTRL) begin
            next_rd = gp_ctrl;
        end else if (wb_adr_i == `IIM_OFF_GP_OUT) begin
            next_rd = {4'h0, gp_out};
        end else if (wb_adr_i == `IIM_OFF_SENS_TYPE) begin
            next_rd = {4'h0, sens_hi_res};
        end else begin
            for (int c = 0; c < AIN_CHANNELS; c++) begin
                if (wb_adr_i == `IIM_OFF_AIN_BASE + 8'(c) * `IIM_PAIR_STRIDE) begin
                    next_rd = ain_val[c][7:0];
                end else if (wb_adr_i == `IIM_OFF_AIN_BASE + 8'(c) * `IIM_PAIR_STRIDE + `IIM_HIGH_STEP) begin
                    next_rd = {6'h00, ain_val[c][9:8]};
                end
            end
            for (int p = 0; p < GP_PINS; p++) begin
                if (wb_adr_i == `IIM_OFF_TEMP_BASE + 8'(p) * `IIM_PAIR_STRIDE) begin
                    next_rd = temp_word[p][7:0];
                end else if (wb_adr_i == `IIM_OFF_TEMP_BASE + 8'(p) * `IIM_PAIR_STRIDE + `IIM_HIGH_STEP) begin
                    next_rd = temp_word[p][15:8];
                end else if (wb_adr_i == `IIM_OFF_HUMID_BASE + 8'(p) * `IIM_PAIR_STRIDE) begin
                    next_rd = humid_word[p][7:0];
                end else if (wb_adr_i == `IIM_OFF_HUMID_BASE + 8'(p) * `IIM_PAIR_STRIDE + `IIM_HIGH_STEP) begin
                    next_rd = humid_word[p][15:8];
                end
            end
        end
    end

    // one wait state; unmapped addresses ack with zero, writes to image ignored
    // read captures current image
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= rd_en;
            if (rd_en && !wb_we_i) begin
                wb_dat_o <= {24'h000000, next_rd};
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_din_low;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i, 1) && !$past(rst_i, 2) && !$past(rst_i, 3) |-> din_low == $past(din_i[7:0], 3);
    endproperty
    a_din_low: assert property (p_din_low) else $error("low input byte not packed from pins");

    property p_din_high;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i, 1) && !$past(rst_i, 2) && !$past(rst_i, 3) |-> din_high == $past(din_i[15:8], 3);
    endproperty
    a_din_high: assert property (p_din_high) else $error("high input byte not packed from pins");

    property p_gp_in;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i, 1) && !$past(rst_i, 2) && !$past(rst_i, 3) |-> gp_in == {4'h0, $past(gp_pin_i[3:0], 3)};
    endproperty
    a_gp_in: assert property (p_gp_in) else $error("pin input byte wrong");

    property p_ain_range;
        @(posedge clk_i) disable iff (rst_i)
        ain_val[0] <= `IIM_AIN_MAX && ain_val[1] <= `IIM_AIN_MAX;
    endproperty
    a_ain_range: assert property (p_ain_range) else $error("analog value out of range");

    sequence s_tenth_sample0;
        adc_i.valid && adc_i.chan == 1'b0 && ain_cnt[0] == 4'h9;
    endsequence

    property p_ain_update;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && $changed(ain_val[0]) |-> $past(adc_i.valid && adc_i.chan == 1'b0 && ain_cnt[0] == 4'h9);
    endproperty
    a_ain_update: assert property (p_ain_update) else $error("analog word changed off the tenth sample");

    property p_ain_restart;
        @(posedge clk_i) disable iff (rst_i)
        s_tenth_sample0 |=> ain_cnt[0] == 4'h0 && ain_sum[0] == 14'h0000;
    endproperty
    a_ain_restart: assert property (p_ain_restart) else $error("average window did not restart");

    property p_reset_inputs;
        @(posedge clk_i)
        $past(rst_i) |-> gp_pin_oe_n_o == '1 && gp_ctrl == 8'h00;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset");

    property p_out_role;
        @(posedge clk_i) disable iff (rst_i)
        role[0] == iim_pkg::IIM_ROLE_OUTPUT |-> !gp_pin_oe_n_o[0] && gp_pin_o[0] == gp_out[0] && !gp_pullup_o[0];
    endproperty
    a_out_role: assert property (p_out_role) else $error("output role not driving pin");

    property p_temp_gate;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && $changed(temp_word[1]) |-> $past(sensor_i.valid && sensor_i.pin == 2'h1
                                                          && role[1] == iim_pkg::IIM_ROLE_SENSOR);
    endproperty
    a_temp_gate: assert property (p_temp_gate) else $error("temperature written outside sensor role");

    property p_neg_msb;
        @(posedge clk_i) disable iff (rst_i)
        sensor_i.valid && sensor_i.pin == 2'h1 && role[1] == iim_pkg::IIM_ROLE_SENSOR
            && sens_hi_res[1] && sensor_i.temp_neg |=> temp_word[1][`IIM_SIGN_BIT];
    endproperty
    a_neg_msb: assert property (p_neg_msb) else $error("negative temperature without sign bit");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack not a single pulse");

endmodule
